/* oru_regfile_top.sv */
`timescale 1ns/10ps
// What this block does
// - sixteen 16-bit word registers, index 0 to 15.
// - words 0-7 readable and writable as upper or lower byte.
// - even-indexed pairs 0-14 form 32-bit registers.
// - quadruples start at 0, 4, 8 or 12, 64 bits wide.
// - register mode returns current contents of selected register, or the product for long multiply.
// - access width follows operand size: byte, word, pair or quadruple.
// - quadruples only for long divide, sign extend and multiply.
// - long multiply: low-order pair (index +2) times source pair into whole quadruple.
// - indirect mode address from word, or pair when segmented and not I/O.
// - word zero and pair zero refused as pointers.
// - indirect I/O takes 16-bit port address from nonzero word.
// - direct address from instruction, 16 bits or segmented short/long.
// - long offset carries 7-bit segment and full 16-bit offset.
// - short offset packs segment and 0-255 offset in one word.
// - indexed address is instruction address plus index word.
// - index register is word 1 to 15, never zero.
// - segment word: format bit on top, segment below, low byte.
module oru_regfile_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [1:0]  op_i,
  input  wire logic [3:0]  dst_idx_i,
  input  wire logic [3:0]  src_idx_i,
  input  wire logic        upper_byte_select_i,
  input  wire logic        segmented_i,
  input  wire logic        io_space_i,
  input  wire logic        wr_en_i,
  input  wire logic [31:0] instr_addr_i,
  input  wire logic [63:0] wr_data_i,
  output logic             ack_o,
  output logic             illegal_o,
  output logic      [63:0] operand_o,
  output logic             ea_valid_o,
  output logic             ea_io_o,
  output logic             ea_long_o,
  output logic      [6:0]  ea_seg_o,
  output logic      [15:0] ea_off_o
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [15:0] word_q  [16];
  logic [1:0]  wr_be   [16];
  logic [15:0] wr_word [16];

  for (genvar g = 0; g < 16; g++) begin : g_word
    oru_word_reg u_word (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .clk_en_i  (clk_en_i),
      .byte_en_i (wr_be[g]),
      .wr_data_i (wr_word[g]),
      .word_o    (word_q[g])
    );
  end

  // ---------------------------------------------------------------
  // neighbour indices
  // ---------------------------------------------------------------
  logic [3:0] idx1;
  logic [3:0] idx2;
  logic [3:0] idx3;
  logic [3:0] src1;

  assign idx1 = dst_idx_i + 4'h1;
  assign idx2 = dst_idx_i + 4'h2;
  assign idx3 = dst_idx_i + 4'h3;
  assign src1 = src_idx_i + 4'h1;

  // ---------------------------------------------------------------
  // legality
  // ---------------------------------------------------------------
  logic is_reg;
  logic idx_ok;
  logic op_ok;
  logic illegal;

  assign is_reg = (mode_i == oru_pkg::MODE_REG);

  always_comb begin
    idx_ok = 1'b1;
    op_ok  = 1'b1;
    unique case (size_i)
      oru_pkg::SIZE_BYTE: idx_ok = (dst_idx_i <= oru_pkg::BYTE_IDX_MAX);
      oru_pkg::SIZE_WORD: idx_ok = 1'b1;
      oru_pkg::SIZE_PAIR: idx_ok = !dst_idx_i[0];
      oru_pkg::SIZE_QUAD: idx_ok = (dst_idx_i[1:0] == 2'h0);
    endcase
    // quad width and the three long ops go together, nothing else may use it
    if ((size_i == oru_pkg::SIZE_QUAD) != (op_i != oru_pkg::OP_PLAIN)) begin
      op_ok = 1'b0;
    end
    if (op_i == oru_pkg::OP_LONG_MULTIPLY && src_idx_i[0]) begin
      op_ok = 1'b0;
    end
  end

  always_comb begin
    illegal = 1'b0;
    unique case (mode_i)
      oru_pkg::MODE_REG: illegal = !idx_ok || !op_ok;
      oru_pkg::MODE_INDIRECT: begin
        // word zero / pair zero would alias the stack-less scratch register
        illegal = (dst_idx_i == 4'h0);
        if (segmented_i && !io_space_i && dst_idx_i[0]) begin
          illegal = 1'b1;
        end
      end
      oru_pkg::MODE_DIRECT:  illegal = 1'b0;
      oru_pkg::MODE_INDEXED: illegal = (dst_idx_i == 4'h0);
    endcase
  end

  // ---------------------------------------------------------------
  // register mode read path and long multiply
  // ---------------------------------------------------------------
  logic [63:0] mul_prod;
  logic [63:0] reg_opnd;
  logic [7:0]  byte_sel;

  assign mul_prod = 64'($signed({word_q[idx2], word_q[idx3]})
                        * $signed({word_q[src_idx_i], word_q[src1]}));

  assign byte_sel = upper_byte_select_i ? word_q[{1'b0, dst_idx_i[2:0]}][15:8]
                                        : word_q[{1'b0, dst_idx_i[2:0]}][7:0];

  always_comb begin
    reg_opnd = 64'h0000000000000000;
    unique case (size_i)
      oru_pkg::SIZE_BYTE: reg_opnd = {56'h00000000000000, byte_sel};
      oru_pkg::SIZE_WORD: reg_opnd = {48'h000000000000, word_q[dst_idx_i]};
      oru_pkg::SIZE_PAIR: reg_opnd = {32'h00000000, word_q[dst_idx_i], word_q[idx1]};
      oru_pkg::SIZE_QUAD: begin
        reg_opnd = {word_q[dst_idx_i], word_q[idx1], word_q[idx2], word_q[idx3]};
        if (op_i == oru_pkg::OP_LONG_MULTIPLY) begin
          reg_opnd = mul_prod;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // write steering, one lane mask per word
  // ---------------------------------------------------------------
  logic        do_write;
  logic [63:0] wdata;

  assign do_write = clk_en_i && req_valid_i && is_reg && !illegal
                    && (wr_en_i || op_i == oru_pkg::OP_LONG_MULTIPLY);
  assign wdata    = (op_i == oru_pkg::OP_LONG_MULTIPLY) ? mul_prod : wr_data_i;

  always_comb begin
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < 16; i++) begin
      k          = 4'(i) - dst_idx_i;
      wr_be[i]   = 2'h0;
      wr_word[i] = 16'h0000;
      if (do_write) begin
        unique case (size_i)
          oru_pkg::SIZE_BYTE: begin
            if (k == 4'h0) begin
              wr_be[i]   = upper_byte_select_i ? 2'h2 : 2'h1;
              wr_word[i] = {wdata[7:0], wdata[7:0]};
            end
          end
          oru_pkg::SIZE_WORD: begin
            if (k == 4'h0) begin
              wr_be[i]   = 2'h3;
              wr_word[i] = wdata[15:0];
            end
          end
          oru_pkg::SIZE_PAIR: begin
            if (k < 4'h2) begin
              wr_be[i]   = 2'h3;
              wr_word[i] = k[0] ? wdata[15:0] : wdata[31:16];
            end
          end
          oru_pkg::SIZE_QUAD: begin
            if (k < 4'h4) begin
              wr_be[i] = 2'h3;
              unique case (k[1:0])
                2'h0: wr_word[i] = wdata[63:48];
                2'h1: wr_word[i] = wdata[47:32];
                2'h2: wr_word[i] = wdata[31:16];
                2'h3: wr_word[i] = wdata[15:0];
              endcase
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // effective address
  // ---------------------------------------------------------------
  logic [15:0] seg_word;
  logic        dir_long;
  logic [15:0] dir_off;
  logic        ea_long;
  logic [6:0]  ea_seg;
  logic [15:0] ea_off;
  logic        flat;

  assign flat     = !segmented_i || io_space_i;
  assign seg_word = instr_addr_i[31:16];
  assign dir_long = seg_word[oru_pkg::SEG_FMT_BIT];
  // short form only reaches the first 256 bytes of a segment
  assign dir_off  = flat ? instr_addr_i[15:0]
                  : dir_long ? instr_addr_i[15:0]
                  : {8'h00, seg_word[oru_pkg::SHORT_MSB:0]};

  always_comb begin
    ea_long = 1'b0;
    ea_seg  = 7'h00;
    ea_off  = 16'h0000;
    unique case (mode_i)
      oru_pkg::MODE_REG: ea_off = 16'h0000;
      oru_pkg::MODE_INDIRECT: begin
        if (flat) begin
          ea_off = word_q[dst_idx_i];
        end else begin
          ea_long = 1'b1;
          ea_seg  = word_q[dst_idx_i][oru_pkg::SEG_MSB:oru_pkg::SEG_LSB];
          ea_off  = word_q[idx1];
        end
      end
      oru_pkg::MODE_DIRECT: begin
        ea_off = dir_off;
        if (!flat) begin
          ea_long = dir_long;
          ea_seg  = seg_word[oru_pkg::SEG_MSB:oru_pkg::SEG_LSB];
        end
      end
      oru_pkg::MODE_INDEXED: begin
        // offset wraps inside the segment, the segment never carries
        ea_off = 16'(dir_off + word_q[dst_idx_i]);
        if (!flat) begin
          ea_long = dir_long;
          ea_seg  = seg_word[oru_pkg::SEG_MSB:oru_pkg::SEG_LSB];
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // answer registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ack_o     <= 1'b0;
      illegal_o <= 1'b0;
    end else if (clk_en_i) begin
      ack_o     <= req_valid_i;
      illegal_o <= req_valid_i && illegal;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      operand_o <= 64'h0000000000000000;
    end else if (clk_en_i && req_valid_i) begin
      operand_o <= (is_reg && !illegal) ? reg_opnd : 64'h0000000000000000;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ea_valid_o <= 1'b0;
      ea_io_o    <= 1'b0;
      ea_long_o  <= 1'b0;
      ea_seg_o   <= 7'h00;
      ea_off_o   <= 16'h0000;
    end else if (clk_en_i && req_valid_i) begin
      ea_valid_o <= !is_reg && !illegal;
      ea_io_o    <= io_space_i && !is_reg && mode_i != oru_pkg::MODE_INDEXED;
      ea_long_o  <= ea_long;
      ea_seg_o   <= ea_seg;
      ea_off_o   <= ea_off;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic go;
  assign go = clk_en_i && req_valid_i;

  ptr_zero_a: assert property (
    go && mode_i == oru_pkg::MODE_INDIRECT && dst_idx_i == 4'h0
    |=> illegal_o && ack_o && !ea_valid_o)
    else $error("pointer zero accepted");

  idx_zero_a: assert property (
    go && mode_i == oru_pkg::MODE_INDEXED && dst_idx_i == 4'h0 |=> illegal_o)
    else $error("index zero accepted");

  pair_odd_a: assert property (
    go && is_reg && size_i == oru_pkg::SIZE_PAIR && dst_idx_i[0]
    |=> illegal_o && operand_o == 64'h0000000000000000)
    else $error("odd pair not refused");

  quad_align_a: assert property (
    go && is_reg && size_i == oru_pkg::SIZE_QUAD && dst_idx_i[1:0] != 2'h0 |=> illegal_o)
    else $error("misaligned quad not refused");

  quad_plain_a: assert property (
    go && is_reg && size_i == oru_pkg::SIZE_QUAD && op_i == oru_pkg::OP_PLAIN |=> illegal_o)
    else $error("quad used by plain op");

  word_read_a: assert property (
    go && is_reg && size_i == oru_pkg::SIZE_WORD && op_i == oru_pkg::OP_PLAIN
    |=> !illegal_o && operand_o == {48'h000000000000, $past(word_q[dst_idx_i])})
    else $error("word operand wrong");

  byte_keep_a: assert property (
    go && is_reg && wr_en_i && size_i == oru_pkg::SIZE_BYTE && !upper_byte_select_i
    && op_i == oru_pkg::OP_PLAIN && dst_idx_i <= oru_pkg::BYTE_IDX_MAX
    |=> word_q[$past(dst_idx_i)][15:8] == $past(word_q[dst_idx_i][15:8])
        && word_q[$past(dst_idx_i)][7:0] == $past(wr_data_i[7:0]))
    else $error("byte write disturbed other byte");

  mult_prod_a: assert property (
    go && is_reg && !illegal && op_i == oru_pkg::OP_LONG_MULTIPLY
    |=> operand_o == $past(mul_prod)
        && {word_q[$past(dst_idx_i)], word_q[$past(idx1)]} == $past(mul_prod[63:32]))
    else $error("long multiply result wrong");

  short_off_a: assert property (
    go && mode_i == oru_pkg::MODE_DIRECT && segmented_i && !io_space_i
    && !instr_addr_i[31]
    |=> ea_off_o[15:8] == 8'h00 && !ea_long_o && ea_seg_o == $past(instr_addr_i[30:24]))
    else $error("short offset malformed");

  index_sum_a: assert property (
    go && mode_i == oru_pkg::MODE_INDEXED && !segmented_i && dst_idx_i != 4'h0
    |=> ea_off_o == 16'($past(instr_addr_i[15:0]) + $past(word_q[dst_idx_i])))
    else $error("indexed sum wrong");

  byte_write_c: cover property (
    go && is_reg && wr_en_i && size_i == oru_pkg::SIZE_BYTE && upper_byte_select_i);
  long_mult_c: cover property (
    go && is_reg && op_i == oru_pkg::OP_LONG_MULTIPLY ##1 !illegal_o);
  seg_index_c: cover property (
    go && mode_i == oru_pkg::MODE_INDEXED && segmented_i ##1 ea_valid_o && ea_long_o);
  io_ind_c: cover property (
    go && mode_i == oru_pkg::MODE_INDIRECT && io_space_i ##1 ea_io_o && ea_valid_o);

endmodule

/* oru_pkg.sv */
package oru_pkg;

  // ---------------------------------------------------------------
  // register file geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_WORDS    = 16;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned OPND_W       = 64;
  localparam int unsigned IDX_W        = 4;
  localparam int unsigned SEG_W        = 7;
  localparam logic [3:0]  BYTE_IDX_MAX = 4'h7;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // ---------------------------------------------------------------
  // segmented address word layout
  // ---------------------------------------------------------------
  localparam int unsigned SEG_FMT_BIT = 15;
  localparam int unsigned SEG_MSB     = 14;
  localparam int unsigned SEG_LSB     = 8;
  localparam int unsigned SHORT_MSB   = 7;

  // ---------------------------------------------------------------
  // addressing modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_REG      = 2'h0;
  localparam logic [1:0] MODE_INDIRECT = 2'h1;
  localparam logic [1:0] MODE_DIRECT   = 2'h2;
  localparam logic [1:0] MODE_INDEXED  = 2'h3;

  // ---------------------------------------------------------------
  // operand sizes
  // ---------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_PAIR = 2'h2;
  localparam logic [1:0] SIZE_QUAD = 2'h3;

  // ---------------------------------------------------------------
  // plain operation and the three operations that touch quadruples
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_PLAIN            = 2'h0;
  localparam logic [1:0] OP_LONG_MULTIPLY    = 2'h1;
  localparam logic [1:0] OP_LONG_DIVIDE      = 2'h2;
  localparam logic [1:0] OP_LONG_SIGN_EXTEND = 2'h3;

endpackage

/* oru_word_reg.sv */
`timescale 1ns/10ps
module oru_word_reg (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic [1:0]  byte_en_i,
  input  wire logic [15:0] wr_data_i,
  output logic      [15:0] word_o
);

  // ---------------------------------------------------------------
  // one word, two independently written byte lanes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      word_o <= oru_pkg::WORD_RESET;
    end else if (clk_en_i) begin
      if (byte_en_i[0]) begin
        word_o[7:0] <= wr_data_i[7:0];
      end
      if (byte_en_i[1]) begin
        word_o[15:8] <= wr_data_i[15:8];
      end
    end
  end

endmodule

/* oru_mem_model.sv */
`timescale 1ns/10ps
// --------------------
// bus stand-in
// --------------------
module oru_mem_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ack_i,
  input  wire logic        ea_valid_i,
  input  wire logic        ea_io_i,
  input  wire logic        ea_long_i,
  input  wire logic [6:0]  ea_seg_i,
  input  wire logic [15:0] ea_off_i,
  output logic      [24:0] addr_o,
  output logic      [7:0]  count_o
);
  // only the ack cycle starts a bus cycle: held addresses are not taken twice
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_o  <= 25'h0000000;
      count_o <= 8'h00;
    end else if (ack_i && ea_valid_i) begin
      addr_o  <= {ea_io_i, ea_long_i, ea_seg_i, ea_off_i};
      count_o <= count_o + 8'h01;
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  // --------------------
  // signals
  // --------------------
  logic        ref_clk_i, rst_n_i, clk_en_i, req_valid_i;
  logic        upper_byte_select_i, segmented_i, io_space_i, wr_en_i;
  logic [1:0]  mode_i, size_i, op_i;
  logic [3:0]  dst_idx_i, src_idx_i;
  logic [31:0] instr_addr_i;
  logic [63:0] wr_data_i, operand_o;
  logic        ack_o, illegal_o, ea_valid_o, ea_io_o, ea_long_o, seen_ill;
  logic [6:0]  ea_seg_o;
  logic [15:0] ea_off_o;
  logic [24:0] mem_addr;
  logic [7:0]  mem_count, pre_cnt;
  logic [2:0]  ref_v;
  int          errors, check_count, stall;

  oru_regfile_top dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .req_valid_i(req_valid_i), .mode_i(mode_i), .size_i(size_i), .op_i(op_i),
    .dst_idx_i(dst_idx_i), .src_idx_i(src_idx_i),
    .upper_byte_select_i(upper_byte_select_i), .segmented_i(segmented_i),
    .io_space_i(io_space_i), .wr_en_i(wr_en_i), .instr_addr_i(instr_addr_i),
    .wr_data_i(wr_data_i), .ack_o(ack_o), .illegal_o(illegal_o),
    .operand_o(operand_o), .ea_valid_o(ea_valid_o), .ea_io_o(ea_io_o),
    .ea_long_o(ea_long_o), .ea_seg_o(ea_seg_o), .ea_off_o(ea_off_o));

  oru_mem_model bus (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ack_i(ack_o),
    .ea_valid_i(ea_valid_o), .ea_io_i(ea_io_o), .ea_long_i(ea_long_o),
    .ea_seg_i(ea_seg_o), .ea_off_i(ea_off_o), .addr_o(mem_addr), .count_o(mem_count));

  always #20 ref_clk_i = ~ref_clk_i;

  // --------------------
  // helpers
  // --------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // f packs {upper byte, segmented, io, write}
  task automatic rq(input logic [1:0] m, s, o, input logic [3:0] d, r, f,
                    input logic [31:0] a, input logic [63:0] wd);
    int n;
    pre_cnt = mem_count;
    mode_i = m;
    size_i = s;
    op_i = o;
    dst_idx_i = d;
    src_idx_i = r;
    {upper_byte_select_i, segmented_i, io_space_i, wr_en_i} = f;
    instr_addr_i = a;
    wr_data_i = wd;
    req_valid_i = 1'b1;
    if (stall > 0) begin
      clk_en_i = 1'b0;
      repeat (stall) @(negedge ref_clk_i);
      chk(ack_o, 64'h0);
      clk_en_i = 1'b1;
    end
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (ack_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 8) begin
      chk({63'h0, ack_o}, 64'h1);
      end_sim();
    end else begin
      seen_ill = illegal_o;
      // one more edge so the bus stand-in has latched the address
      @(negedge ref_clk_i);
      ref_v = {seen_ill, ea_valid_o, mem_count === pre_cnt};
    end
  endtask

  task automatic wr(input logic [1:0] s, input logic [3:0] d, input logic u,
                    input logic [63:0] wd);
    rq(oru_pkg::MODE_REG, s, 2'h0, d, 4'h0, {u, 3'b001}, 32'h0, wd);
  endtask

  task automatic rd(input logic [1:0] s, input logic [3:0] d, input logic u);
    rq(oru_pkg::MODE_REG, s, 2'h0, d, 4'h0, {u, 3'b000}, 32'h0, 64'h0);
  endtask

  task automatic qd(input logic [1:0] o, input logic [3:0] d, r);
    rq(oru_pkg::MODE_REG, 2'h3, o, d, r, 4'h0, 32'h0, 64'h0);
  endtask

  task automatic ind(input logic [3:0] d, f);
    rq(oru_pkg::MODE_INDIRECT, 2'h0, 2'h0, d, 4'h0, f, 32'h0, 64'h0);
  endtask

  task automatic dir(input logic [3:0] f, input logic [31:0] a);
    rq(oru_pkg::MODE_DIRECT, 2'h0, 2'h0, 4'h0, 4'h0, f, a, 64'h0);
  endtask

  task automatic idx(input logic [3:0] d, f, input logic [31:0] a);
    rq(oru_pkg::MODE_INDEXED, 2'h0, 2'h0, d, 4'h0, f, a, 64'h0);
  endtask

  // --------------------
  // scenarios
  // --------------------
  task automatic t_word();
    rd(2'h1, 4'h1, 1'b0);
    chk(operand_o, 64'h0);
    wr(2'h1, 4'hF, 1'b0, 64'h3FFF);
    rd(2'h1, 4'hF, 1'b0);
    chk(operand_o, 64'h3FFF);
    stall = 3;
    wr(2'h1, 4'h1, 1'b0, 64'hBEEF);
    stall = 0;
    rd(2'h1, 4'h1, 1'b0);
    chk({ref_v, operand_o[15:0]}, {3'h1, 16'hBEEF});
    $display("word test done");
  endtask

  task automatic t_byte();
    wr(2'h1, 4'h3, 1'b0, 64'h1111);
    wr(2'h0, 4'h3, 1'b1, 64'hF3);
    rd(2'h1, 4'h3, 1'b0);
    chk(operand_o, 64'hF311);
    rd(2'h0, 4'h3, 1'b1);
    chk(operand_o, 64'hF3);
    rd(2'h0, 4'h3, 1'b0);
    chk(operand_o, 64'h11);
    wr(2'h0, 4'h8, 1'b0, 64'hAA);
    chk(ref_v, 3'h5);
    rd(2'h1, 4'h8, 1'b0);
    chk(operand_o, 64'h0);
    $display("byte test done");
  endtask

  task automatic t_pair();
    wr(2'h2, 4'h2, 1'b0, 64'h12345678);
    rd(2'h1, 4'h2, 1'b0);
    chk(operand_o, 64'h1234);
    rd(2'h1, 4'h3, 1'b0);
    chk(operand_o, 64'h5678);
    wr(2'h2, 4'hE, 1'b0, 64'h0BADCAFE);
    rd(2'h2, 4'hE, 1'b0);
    chk(operand_o, 64'h0BADCAFE);
    wr(2'h2, 4'h5, 1'b0, 64'h1);
    chk(ref_v, 3'h5);
    rd(2'h1, 4'h5, 1'b0);
    chk(operand_o, 64'h0);
    $display("pair test done");
  endtask

  task automatic t_quad();
    wr(2'h2, 4'hA, 1'b0, 64'h3);
    wr(2'h2, 4'hC, 1'b0, 64'hFFFFFFFB);
    qd(oru_pkg::OP_LONG_MULTIPLY, 4'h8, 4'hC);
    chk(operand_o, 64'hFFFFFFFFFFFFFFF1);
    qd(oru_pkg::OP_LONG_DIVIDE, 4'h8, 4'h0);
    chk(operand_o, 64'hFFFFFFFFFFFFFFF1);
    qd(oru_pkg::OP_LONG_SIGN_EXTEND, 4'hC, 4'h0);
    chk(operand_o, 64'hFFFFFFFB0BADCAFE);
    rd(2'h3, 4'h8, 1'b0);
    chk(ref_v, 3'h5);
    rq(oru_pkg::MODE_REG, 2'h2, 2'h1, 4'h8, 4'hC, 4'h0, 32'h0, 64'h0);
    chk(ref_v, 3'h5);
    qd(oru_pkg::OP_LONG_DIVIDE, 4'h6, 4'h0);
    chk(ref_v, 3'h5);
    qd(oru_pkg::OP_LONG_MULTIPLY, 4'h8, 4'hD);
    chk(ref_v, 3'h5);
    rd(2'h2, 4'hC, 1'b0);
    chk(operand_o, 64'hFFFFFFFB);
    rq(oru_pkg::MODE_REG, 2'h3, oru_pkg::OP_LONG_SIGN_EXTEND, 4'h4, 4'h0, 4'h1, 32'h0,
       64'h0123456789ABCDEF);
    rd(2'h1, 4'h6, 1'b0);
    chk(operand_o, 64'h89AB);
    $display("quad test done");
  endtask

  task automatic t_ind();
    wr(2'h1, 4'h7, 1'b0, 64'h1234);
    ind(4'h7, 4'h0);
    chk(mem_addr, {2'b00, 7'h00, 16'h1234});
    ind(4'h7, 4'h2);
    chk(mem_addr, {2'b10, 7'h00, 16'h1234});
    ind(4'h1, 4'h0);
    chk(mem_addr, {2'b00, 7'h00, 16'hBEEF});
    wr(2'h2, 4'h4, 1'b0, 64'h8500ABCD);
    ind(4'h4, 4'h4);
    chk(mem_addr, {2'b01, 7'h05, 16'hABCD});
    ind(4'h2, 4'h4);
    chk(mem_addr, {2'b01, 7'h12, 16'h5678});
    ind(4'h0, 4'h0);
    chk(ref_v, 3'h5);
    ind(4'h5, 4'h4);
    chk(ref_v, 3'h5);
    ind(4'h0, 4'h2);
    chk(ref_v, 3'h5);
    $display("indirect test done");
  endtask

  task automatic t_dir();
    dir(4'h0, 32'hFFFF2000);
    chk(mem_addr, {2'b00, 7'h00, 16'h2000});
    dir(4'h6, 32'h83124567);
    chk(mem_addr, {2'b10, 7'h00, 16'h4567});
    dir(4'h4, 32'h83124567);
    chk(mem_addr, {2'b01, 7'h03, 16'h4567});
    dir(4'h4, 32'hFFFF0000);
    chk(mem_addr, {2'b01, 7'h7F, 16'h0000});
    dir(4'h4, 32'h05FFABCD);
    chk(mem_addr, {2'b00, 7'h05, 16'h00FF});
    $display("direct test done");
  endtask

  task automatic t_idx();
    wr(2'h1, 4'h6, 1'b0, 64'h0010);
    idx(4'h6, 4'h0, 32'h000000F0);
    chk(mem_addr, {2'b00, 7'h00, 16'h0100});
    idx(4'h6, 4'h0, 32'h0000FFF8);
    chk(mem_addr, {2'b00, 7'h00, 16'h0008});
    idx(4'h6, 4'h4, 32'h83124000);
    chk(mem_addr, {2'b01, 7'h03, 16'h4010});
    idx(4'hF, 4'h0, 32'h00000002);
    chk(mem_addr, {2'b00, 7'h00, 16'hCB00});
    idx(4'h0, 4'h0, 32'h00000002);
    chk(ref_v, 3'h5);
    $display("indexed test done");
  endtask

  // mid-run reset: held answers and every word go back to zero
  task automatic t_rst();
    rst_n_i = 1'b0;
    @(negedge ref_clk_i);
    chk({ea_valid_o, ea_off_o}, 64'h0);
    rst_n_i = 1'b1;
    rd(2'h1, 4'hF, 1'b0);
    chk(operand_o, 64'h0);
    $display("reset test done");
  endtask

  // --------------------
  // main
  // --------------------
  initial begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    req_valid_i = 1'b0;
    {mode_i, size_i, op_i, dst_idx_i, src_idx_i} = 14'h0;
    {upper_byte_select_i, segmented_i, io_space_i, wr_en_i} = 4'h0;
    instr_addr_i = 32'h0;
    wr_data_i = 64'h0;
    errors = 0;
    check_count = 0;
    stall = 0;
    repeat (6) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_word();
    t_byte();
    t_pair();
    t_quad();
    t_ind();
    t_dir();
    t_idx();
    t_rst();
    end_sim();
  end
endmodule
